/* File: rtl/conv_ctrl_pkg.sv */
// Shared constants for the converter digital control block.
// Assumes a single 50 MHz system clock and active-low async reset.
package conv_ctrl_pkg;
  localparam int          DATA_W          = 12;
  localparam int          PIPE_DEPTH      = 6;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          RECOVER_NS      = 300;
  // Least time, rounded up to whole cycles
  localparam int          RECOVER_CYC     = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] DATA_RESET      = 12'h000;
  localparam logic [11:0] OUT_HIZ_RESET   = 12'hFFF;
  localparam logic [4:0]  RECOVER_CNT_W0  = 5'h00;
  localparam logic [2:0]  PIPE_CNT_ZERO   = 3'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_RUN} conv_state_t;
endpackage : conv_ctrl_pkg

/* File: rtl/sample_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  ////////////////////////////////////////////////////////////////////////
  // Pointer arithmetic
  always_comb begin
    full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty       = (wr_ptr == rd_ptr);
    do_wr       = in_valid && !full && !flush;
    do_rd       = !empty && (!out_valid || out_ready) && !flush;
    next_wr_ptr = flush ? rd_ptr : (do_wr ? wr_ptr + (AW+1)'(1) : wr_ptr);
    next_rd_ptr = do_rd ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  // Storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers and registered read port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
      in_ready  <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      in_ready <= !((next_wr_ptr[AW] != next_rd_ptr[AW]) &&
                    (next_wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]));
      if (flush) begin
        out_valid <= 1'b0;
      end else if (do_rd) begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_ptr[AW-1:0]];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : sample_fifo
`default_nettype wire

/* File: rtl/conv_ctrl.sv */
// Digital control side of a 12-bit pipelined sampling converter.
// Assumes sample_clk, out_enable_n, power_down_request come from pins
// outside sys_clk's domain; sample_in is the quantiser output, sampled
// with sample_clk rising edges detected in sys_clk.
// How it works
// - Each acquisition is timed only by the sampling clock input.
// - Output enable high puts all data pins in high impedance.
// - Output enable low drives data pins with conversion results.
// - Sampling and pipeline advance continue regardless of output enable.
// - Power-down high holds the converter idle with no valid conversions.
// - Data outputs are undefined during power-down; capture treats them invalid.
// - Entering power-down corrupts pipeline contents; in-flight results are discarded.
// - Analog input acquired on each rising sampling clock edge.
// - Each result appears after six sampling clock cycles of pipeline delay; the output FIFO here adds a seventh.
// - One output word per sampling clock cycle.
// - Twelve offset-binary pins, valid only while enable and power-down low.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        sample_clk,
  input  wire logic        out_enable_n,
  input  wire logic        power_down_request,
  input  wire logic [11:0] sample_in,
  output logic      [11:0] data_out,
  output logic      [11:0] data_oe_n,
  output logic             data_valid,
  output logic             fifo_full_drop,
  output logic             powered_down
);
  localparam int W = conv_ctrl_pkg::DATA_W;

  logic [2:0]   clk_sync;
  logic [1:0]   oe_sync;
  logic [1:0]   pd_sync;
  logic [W-1:0] in_meta;
  logic [W-1:0] in_sync;
  logic         clk_rise;
  logic         oe_n_s;
  logic         pd_s;

  conv_ctrl_pkg::conv_state_t state;
  conv_ctrl_pkg::conv_state_t next_state;
  logic [4:0]   rec_cnt;
  logic [4:0]   next_rec_cnt;

  logic [W-1:0] pipe_data [conv_ctrl_pkg::PIPE_DEPTH];
  logic [conv_ctrl_pkg::PIPE_DEPTH-1:0] pipe_ok;
  logic [W-1:0] next_pipe_data [conv_ctrl_pkg::PIPE_DEPTH];
  logic [conv_ctrl_pkg::PIPE_DEPTH-1:0] next_pipe_ok;

  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] pop_data;
  logic         pop_valid;
  logic         pop_ready;
  logic         flush;

  logic [W-1:0] next_data_out;
  logic [W-1:0] next_data_oe_n;
  logic         next_data_valid;
  logic         next_drop;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_sync <= 3'h0;
      oe_sync  <= 2'h3;
      pd_sync  <= 2'h3;
      in_meta  <= conv_ctrl_pkg::DATA_RESET;
      in_sync  <= conv_ctrl_pkg::DATA_RESET;
    end else begin
      clk_sync <= {clk_sync[1:0], sample_clk};
      oe_sync  <= {oe_sync[0], out_enable_n};
      pd_sync  <= {pd_sync[0], power_down_request};
      in_meta  <= sample_in;
      in_sync  <= in_meta;
    end
  end

  // Rising edge of the sampling clock, seen past two stages
  always_comb begin
    clk_rise = clk_sync[1] && !clk_sync[2];
    oe_n_s   = oe_sync[1];
    pd_s     = pd_sync[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state: idle, recovering, running
  always_comb begin
    next_state   = state;
    next_rec_cnt = rec_cnt;
    unique case (state)
      conv_ctrl_pkg::ST_IDLE: begin
        next_rec_cnt = conv_ctrl_pkg::RECOVER_CNT_W0;
        if (!pd_s) begin
          next_state = conv_ctrl_pkg::ST_RECOVER;
        end
      end
      conv_ctrl_pkg::ST_RECOVER: begin
        if (pd_s) begin
          next_state = conv_ctrl_pkg::ST_IDLE;
        end else if (rec_cnt == 5'(conv_ctrl_pkg::RECOVER_CYC - 1)) begin
          next_state = conv_ctrl_pkg::ST_RUN;
        end else begin
          next_rec_cnt = rec_cnt + 5'h01;
        end
      end
      conv_ctrl_pkg::ST_RUN: begin
        if (pd_s) begin
          next_state = conv_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= conv_ctrl_pkg::ST_IDLE;
      rec_cnt <= conv_ctrl_pkg::RECOVER_CNT_W0;
    end else begin
      state   <= next_state;
      rec_cnt <= next_rec_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Six-stage pipeline, one step per sampling clock rise
  always_comb begin
    next_pipe_data = pipe_data;
    next_pipe_ok   = pipe_ok;
    if (state != conv_ctrl_pkg::ST_RUN) begin
      next_pipe_ok = '0;
    end else if (clk_rise) begin
      next_pipe_data[0] = in_sync;
      next_pipe_ok[0]   = 1'b1;
      for (int i = 1; i < conv_ctrl_pkg::PIPE_DEPTH; i++) begin
        next_pipe_data[i] = pipe_data[i-1];
        next_pipe_ok[i]   = pipe_ok[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe_ok <= '0;
      for (int i = 0; i < conv_ctrl_pkg::PIPE_DEPTH; i++) begin
        pipe_data[i] <= conv_ctrl_pkg::DATA_RESET;
      end
    end else begin
      pipe_ok   <= next_pipe_ok;
      pipe_data <= next_pipe_data;
    end
  end

  // One word per rise leaves the pipeline into the FIFO
  always_comb begin
    push_valid = clk_rise && pipe_ok[conv_ctrl_pkg::PIPE_DEPTH-1] &&
                 (state == conv_ctrl_pkg::ST_RUN);
    flush      = (state != conv_ctrl_pkg::ST_RUN);
    pop_ready  = clk_rise; // Pins change once per sample period
  end

  sample_fifo #(
    .WIDTH (W),
    .DEPTH (conv_ctrl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_data   (pipe_data[conv_ctrl_pkg::PIPE_DEPTH-1]),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (pop_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .flush     (flush)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output pins and status
  always_comb begin
    next_data_out   = data_out;
    next_data_valid = data_valid;
    next_drop       = push_valid && !push_ready;
    if (flush) begin
      next_data_valid = 1'b0;
    end else if (clk_rise) begin
      next_data_out   = pop_data;
      next_data_valid = pop_valid && !oe_n_s;
    end
    if (oe_n_s) begin
      next_data_valid = 1'b0;
    end
    next_data_oe_n = {W{oe_n_s}};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out       <= conv_ctrl_pkg::DATA_RESET;
      data_oe_n      <= conv_ctrl_pkg::OUT_HIZ_RESET;
      data_valid     <= 1'b0;
      fifo_full_drop <= 1'b0;
      powered_down   <= 1'b1;
    end else begin
      data_out       <= next_data_out;
      data_oe_n      <= next_data_oe_n;
      data_valid     <= next_data_valid;
      fifo_full_drop <= next_drop;
      powered_down   <= (next_state == conv_ctrl_pkg::ST_IDLE);
    end
  end
endmodule : conv_ctrl
`default_nettype wire

/* File: tb/conv_ctrl_sva.sv */
// Port-level checks on the converter control block.
// Assumes sampling clock halves of at least four sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        sample_clk,
  input wire logic        out_enable_n,
  input wire logic        power_down_request,
  input wire logic [11:0] sample_in,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe_n,
  input wire logic        data_valid,
  input wire logic        fifo_full_drop,
  input wire logic        powered_down
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  // Held input levels, long enough to pass sync; the 12-cycle holds also cover one word
  sequence oe_high_s; out_enable_n [*8] ##1 out_enable_n [*4]; endsequence
  sequence oe_low_s; !out_enable_n [*4]; endsequence
  sequence pd_held_s; power_down_request [*8] ##1 power_down_request [*4]; endsequence
  hiz_when_off_a: assert property (out_enable_n [*4] |-> data_oe_n == 12'hFFF)
    else $error("data pins driven while enable high");
  drive_when_on_a: assert property (oe_low_s |-> data_oe_n == 12'h000)
    else $error("data pins released while enable low");
  valid_needs_oe_a: assert property (oe_high_s |-> !data_valid)
    else $error("valid word while enable high");
  idle_in_pd_a: assert property (pd_held_s |-> powered_down && !data_valid)
    else $error("not idle while power-down held");
  wake_gap_a: assert property ($fell(powered_down) |-> !data_valid [*8] ##1 !data_valid [*7])
    else $error("valid word too soon after power-down");
  word_hold_a: assert property ($changed(data_out) |=> $stable(data_out) [*3])
    else $error("more than one word per sampling clock");
  rise_timed_a: assert property ($changed(data_out) |-> $past(sample_clk, 2))
    else $error("word change not after a sampling clock rise");
  drop_pulse_a: assert property (fifo_full_drop |=> !fifo_full_drop)
    else $error("drop flag longer than one cycle");
  no_word_loss_a: assert property (!fifo_full_drop)
    else $error("word lost at the buffer");
endmodule : conv_ctrl_sva
bind conv_ctrl conv_ctrl_sva i_sva (.sys_clk(sys_clk), .arst_n(arst_n), .sample_clk(sample_clk),
  .out_enable_n(out_enable_n), .power_down_request(power_down_request), .sample_in(sample_in),
  .data_out(data_out), .data_oe_n(data_oe_n), .data_valid(data_valid),
  .fifo_full_drop(fifo_full_drop), .powered_down(powered_down));
`default_nettype wire

/* File: tb/capture_model.sv */
// Capture-side model: sampling clock and quantiser words.
// Assumes sys_clk at 50 MHz; the clock runs free at sys_clk/8.
`timescale 1ns/1ps
`default_nettype none
module capture_model (
  input  wire logic        sys_clk,
  output logic             sample_clk,
  output logic      [11:0] sample_in,
  output logic      [11:0] rise_count
);
  logic [1:0] phase = 2'h0;
  initial begin
    sample_clk = 1'b0;
    sample_in  = 12'hFF0;
    rise_count = 12'hFF0;
  end
  // 6.25 MHz, 50% duty, never paused; word set up at the fall
  always @(posedge sys_clk) begin
    phase <= #1 phase + 2'h1;
    if (phase == 2'h3) begin
      sample_clk <= #1 ~sample_clk;
      if (!sample_clk) rise_count <= #1 rise_count + 12'h001;
      else sample_in <= #1 rise_count;
    end
  end
endmodule : capture_model
`default_nettype wire

/* File: tb/conv_ctrl_tb.sv */
// Self-checking bench for the converter control block.
// Assumes capture_model supplies the sampling clock and words.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module conv_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        arst_n, out_enable_n, power_down_request, sample_clk;
  logic [11:0] sample_in, rise_count, data_out, data_oe_n, w, prev;
  logic        data_valid, fifo_full_drop, powered_down;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          waited;
  int          drop_seen = 0;
  localparam logic [11:0] LAT = 12'(conv_ctrl_pkg::PIPE_DEPTH + 2);
  // Sampling clock period of the capture model, in sys_clk cycles
  localparam int RISE_CYC = 8;
  // Bounds on the first valid word after power-down release
  localparam int WAKE_LO  = conv_ctrl_pkg::RECOVER_CYC + RISE_CYC * (conv_ctrl_pkg::PIPE_DEPTH + 1);
  localparam int WAKE_HI  = WAKE_LO + RISE_CYC * 2;
  // Counts any lost word out of reset
  always @(posedge sys_clk) begin
    if (arst_n === 1'b1 && fifo_full_drop !== 1'b0) drop_seen++;
  end
  always #10 sys_clk = ~sys_clk;
  capture_model i_model (.sys_clk(sys_clk), .sample_clk(sample_clk), .sample_in(sample_in),
    .rise_count(rise_count));
  conv_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .sample_clk(sample_clk),
    .out_enable_n(out_enable_n), .power_down_request(power_down_request), .sample_in(sample_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_valid(data_valid),
    .fifo_full_drop(fifo_full_drop), .powered_down(powered_down));
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Wait, bounded, for the next valid word
  task automatic next_word;
    prev = data_out;
    waited = 0;
    while ((data_out === prev || data_valid !== 1'b1) && waited < 400) begin
      @(posedge sys_clk);
      #2;
      waited++;
    end
    w = data_out;
    `CHECK("word wait", 1'b1, waited < 400)
  endtask : next_word
  // Steady stream across the code wrap, exact latency
  task automatic t_stream;
    next_word();
    repeat (20) begin
      next_word();
      `CHECK("next word", prev + 12'h001, w)
      `CHECK("latency", LAT, rise_count - w)
      `CHECK("pins driven", 12'h000, data_oe_n)
    end
  endtask : t_stream
  // Power-down idles, then recovery and refill with fresh words only
  task automatic t_power_down;
    @(posedge sys_clk);
    power_down_request <= #1 1'b1;
    repeat (20) @(posedge sys_clk);
    #2;
    `CHECK("powered down", 1'b1, powered_down)
    `CHECK("valid in pd", 1'b0, data_valid)
    @(posedge sys_clk);
    power_down_request <= #1 1'b0;
    waited = 0;
    while (data_valid !== 1'b1 && waited < 600) begin
      @(posedge sys_clk);
      #2;
      waited++;
    end
    `CHECK("recovery wait", 1'b1, waited > WAKE_LO && waited < WAKE_HI)
    `CHECK("fresh word", LAT, rise_count - data_out)
  endtask : t_power_down
  // Enable high hides words, conversion keeps running
  task automatic t_out_enable;
    @(posedge sys_clk);
    out_enable_n <= #1 1'b1;
    repeat (20) @(posedge sys_clk);
    #2;
    `CHECK("pins released", 12'hFFF, data_oe_n)
    `CHECK("valid hidden", 1'b0, data_valid)
    @(posedge sys_clk);
    out_enable_n <= #1 1'b0;
    waited = 0;
    while (data_valid !== 1'b1 && waited < 30) begin
      @(posedge sys_clk);
      #2;
      waited++;
    end
    `CHECK("no refill", 1'b1, waited < 30)
    next_word();
    next_word();
    `CHECK("next word", prev + 12'h001, w)
    `CHECK("latency kept", LAT, rise_count - w)
    `CHECK("no drop", 0, drop_seen)
  endtask : t_out_enable
  // Reset in mid-run: pins released and idle, then a clean restart
  task automatic t_reset;
    @(posedge sys_clk);
    arst_n <= #1 1'b0;
    repeat (4) @(posedge sys_clk);
    #2;
    `CHECK("reset pins", conv_ctrl_pkg::OUT_HIZ_RESET, data_oe_n)
    `CHECK("reset word", conv_ctrl_pkg::DATA_RESET, data_out)
    `CHECK("reset valid", 1'b0, data_valid)
    `CHECK("reset idle", 1'b1, powered_down)
    `CHECK("reset drop", 1'b0, fifo_full_drop)
    @(posedge sys_clk);
    arst_n <= #1 1'b1;
    next_word();
    `CHECK("restart latency", LAT, rise_count - w)
    `CHECK("restart driven", 12'h000, data_oe_n)
  endtask : t_reset
  ////////////////////////////////////////////////////////////
  // Reset, then scenarios; the capture side keeps running in pd
  initial begin
    arst_n = 1'b0;
    out_enable_n = 1'b0;
    power_down_request = 1'b0;
    repeat (16) @(posedge sys_clk);
    arst_n <= #1 1'b1;
    t_stream();
    t_power_down();
    t_out_enable();
    t_reset();
    end_of_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : conv_ctrl_tb
`default_nettype wire
